// ===== bench/host_driver_model.sv
// Purpose: driver-side model that builds and offers descriptors
// Assumes: descriptors offered only while the block is idle
// Notes: offer returns just after the take edge
`timescale 1ns/1ps
`default_nettype none
module host_driver_model (
    input wire logic i_clk,
    input wire logic i_busy,
    output logic o_desc_valid,
    output logic [63:0] o_desc_word0,
    output logic [63:0] o_desc_word1
);
    initial
    begin
        {o_desc_valid, o_desc_word0, o_desc_word1} = '0;
    end
    function automatic logic [63:0] data_w1(input logic [7:0] cmd, input logic [15:0] tag);
        return {tag, 16'h0000, cmd & 8'hDF, 24'h000000};
    endfunction : data_w1
    function automatic logic [63:0] ctx_w1(input logic seg, input logic [19:0] pay);
        return {16'h0100, 8'h36, 8'h00, 8'h20 | {5'h00, seg, 2'h0}, 4'h0, pay};
    endfunction : ctx_w1
    // waiting for idle avoids silent refusal; contexts only go between packets
    task automatic offer(input logic [63:0] w0, input logic [63:0] w1, input int idle);
        repeat (idle) @(posedge i_clk);
        do @(negedge i_clk); while (i_busy);
        @(posedge i_clk);
        o_desc_valid <= 1'b1;
        o_desc_word0 <= w0;
        o_desc_word1 <= w1;
        @(posedge i_clk);
        o_desc_valid <= 1'b0;
        o_desc_word0 <= ~w0;
        o_desc_word1 <= ~w1;
    endtask : offer
endmodule : host_driver_model
`default_nettype wire

// ===== bench/tb_top.sv
// Purpose: directed tests of write-back, tagging and context handling
// Assumes: default design parameters, underrun feature present
// Notes: MAC events are pulsed by the bench
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_clk, i_reset, i_global_tagging_enable, i_no_retry_on_underrun, i_full_duplex, i_gigabit;
    logic i_tx_collision, i_tx_underrun, i_tx_sent, i_desc_valid, o_busy, o_wb_valid, o_tag_insert;
    logic o_canonical_form_bit;
    logic [15:0] i_vlan_type, i_tx_byte_count, i_packet_length, o_ip_sum_last;
    logic [63:0] i_desc_word0, i_desc_word1;
    logic [7:0] i_collision_threshold, o_wb_status, o_ip_sum_start, o_l4_sum_insert_offset;
    logic [2:0] o_user_priority;
    logic [11:0] o_vlan_id;
    logic [19:0] o_total_payload_length;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    int coll[4] = '{1, 1, 3, 0};
    logic [15:0] cnt[4] = '{16'h003F, 16'h0200, 16'h0000, 16'h0000};
    logic [7:0] ex[4] = '{8'h01, 8'h05, 8'h03, 8'h09};
    host_driver_model host (.i_clk, .i_busy(o_busy), .o_desc_valid(i_desc_valid), .o_desc_word0(i_desc_word0),
        .o_desc_word1(i_desc_word1));
    tx_descriptor_status_context dut (.i_clk, .i_reset, .i_desc_valid, .i_desc_word0, .i_desc_word1,
        .i_global_tagging_enable, .i_vlan_type, .i_no_retry_on_underrun, .i_collision_threshold, .i_full_duplex,
        .i_gigabit, .i_tx_start(1'b0), .i_tx_collision, .i_tx_byte_count, .i_tx_underrun, .i_tx_sent,
        .i_packet_length, .o_data_desc(), .o_busy, .o_wb_valid, .o_wb_status, .o_retry(), .o_abandon(),
        .o_tag_insert, .o_tag_type(), .o_user_priority, .o_canonical_form_bit, .o_vlan_id, .o_use_extended_ctx(),
        .o_ip_sum_start, .o_ip_sum_insert_offset(), .o_ip_sum_last, .o_l4_sum_start(), .o_l4_sum_insert_offset,
        .o_l4_sum_last(), .o_segmentation_enable(), .o_total_payload_length, .o_prototype_header_length(),
        .o_max_segment_size());
    task automatic check(input string name, input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic wb(input logic [7:0] exp);
        int n;
        n = 0;
        do
        begin
            @(negedge i_clk);
            n++;
        end
        while (o_wb_valid !== 1'b1 && n < 20);
        check("write-back pulse", o_wb_valid, 1'b1);
        check("write-back status", o_wb_status, exp);
    endtask : wb
    task automatic mac(input int nc, input logic und, input logic [15:0] bytes);
        i_tx_byte_count <= bytes;
        repeat (nc)
        begin
            @(posedge i_clk);
            i_tx_collision <= 1'b1;
            @(posedge i_clk);
            i_tx_collision <= 1'b0;
        end
        @(posedge i_clk);
        i_tx_underrun <= und;
        @(posedge i_clk);
        i_tx_underrun <= 1'b0;
        i_tx_sent <= 1'b1;
        @(posedge i_clk);
        i_tx_sent <= 1'b0;
    endtask : mac
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    initial
    begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    // a hung handshake would otherwise stall the run forever
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            report_and_stop;
        end
    end
    initial
    begin
        int n;
        i_reset = 1'b1;
        {i_global_tagging_enable, i_no_retry_on_underrun, i_full_duplex, i_gigabit} = 4'h0;
        {i_tx_collision, i_tx_underrun, i_tx_sent} = 3'h0;
        i_vlan_type = 16'h88A8;
        i_collision_threshold = 8'h02;
        i_tx_byte_count = 16'h0000;
        i_packet_length = 16'h05DC;
        repeat (12) @(posedge i_clk);
        i_reset <= 1'b0;
        host.offer(64'h0, host.data_w1(8'h09, 16'h0000), 0);
        wb(8'h01);
        host.offer(64'h0, host.data_w1(8'h01, 16'h0000), 0);
        n = 0;
        repeat (6)
        begin
            @(negedge i_clk);
            n += int'(o_wb_valid === 1'b1);
        end
        check("unrequested write-backs", n, 0);
        $display("test report done");
        for (int k = 0; k < 4; k++)
        begin
            @(posedge i_clk);
            i_global_tagging_enable <= (k != 1);
            host.offer(64'h0, host.data_w1(k == 3 ? 8'h01 : k == 2 ? 8'h40 : 8'h41, 16'hB5C3), 3);
            @(negedge i_clk);
            check("tag insert", o_tag_insert, k == 0);
            // the split fields only show while a tag is being inserted
            if (k == 0)
                check("tag fields", {o_user_priority, o_canonical_form_bit, o_vlan_id}, 16'hB5C3);
        end
        $display("test tagging done");
        host.offer(64'h0000_2824_0000_1A0E, host.ctx_w1(1'b1, 20'h12345), 0);
        @(negedge i_clk);
        check("ip start", o_ip_sum_start, 8'h0E);
        check("l4 insert", o_l4_sum_insert_offset, 8'h28);
        check("ip last", o_ip_sum_last, 16'h05DB);
        check("payload", o_total_payload_length, 20'h12345);
        host.offer(64'h0000_3030_0000_1410, host.ctx_w1(1'b0, 20'h00777), 0);
        host.offer(64'h0, host.data_w1(8'h09, 16'h0000), 0);
        wb(8'h01);
        check("payload kept", o_total_payload_length, 20'h12345);
        check("ip start kept", o_ip_sum_start, 8'h10);
        $display("test context done");
        for (int k = 0; k < 4; k++)
        begin
            @(posedge i_clk);
            i_gigabit <= (k == 1);
            host.offer(64'h0, host.data_w1(8'h19, 16'h0000), 2);
            fork
                mac(coll[k], k == 3, cnt[k]);
                wb(ex[k]);
            join
        end
        $display("test mac events done");
        report_and_stop;
    end
endmodule : tb_top
`default_nettype wire

// ===== bench/tx_status_asserts.sv
// Purpose: port-level checks of write-back, tag and context behaviour
// Assumes: single clock, asynchronous active-high reset
// Notes: bound into the design top; watches its ports only
`timescale 1ns/1ps
`default_nettype none
module tx_status_asserts (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_desc_valid,
    input wire logic [63:0] i_desc_word0,
    input wire logic [63:0] i_desc_word1,
    input wire logic i_global_tagging_enable,
    input wire logic [15:0] i_vlan_type,
    input wire logic o_data_desc,
    input wire logic o_busy,
    input wire logic o_wb_valid,
    input wire logic [7:0] o_wb_status,
    input wire logic o_tag_insert,
    input wire logic [15:0] o_tag_type,
    input wire logic [7:0] o_ip_sum_start,
    input wire logic [7:0] o_l4_sum_start,
    input wire logic [19:0] o_total_payload_length
);
    logic ctx_take;
    assign ctx_take = i_desc_valid && !o_busy && i_desc_word1[29] && i_desc_word1[23:20] == 4'h0;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    AST_DONE_SET: assert property (o_wb_valid |-> o_wb_status[0])
        else $error("write-back without done flag");
    AST_RSV_ZERO: assert property (o_wb_valid |-> o_wb_status[7:4] == 4'h0)
        else $error("reserved status bits set");
    AST_REPORT: assert property (o_data_desc && i_desc_word1[27] && !i_desc_word1[28] |-> ##[1:4] o_wb_valid)
        else $error("requested write-back missing");
    AST_NO_REPORT: assert property (o_data_desc && !i_desc_word1[27] && !i_desc_word1[28] |=> !o_wb_valid [*4])
        else $error("write-back without request");
    AST_CTX_NODATA: assert property (ctx_take |-> !o_data_desc)
        else $error("context taken as data");
    AST_CTX_LOAD: assert property (ctx_take |=> o_ip_sum_start == $past(i_desc_word0[7:0])
        && o_l4_sum_start == $past(i_desc_word0[39:32]))
        else $error("checksum context not loaded from first word");
    AST_CTX_KEEP: assert property (!ctx_take |=> $stable(o_ip_sum_start) && $stable(o_l4_sum_start))
        else $error("context changed without context descriptor");
    AST_SEG_IGNORED: assert property (ctx_take && !i_desc_word1[26] |=> $stable(o_total_payload_length))
        else $error("segmentation field taken while disabled");
    AST_TAG_SRC: assert property (o_tag_insert |-> i_global_tagging_enable && o_tag_type == i_vlan_type)
        else $error("tag inserted wrongly");
endmodule : tx_status_asserts
bind tx_descriptor_status_context tx_status_asserts chk (.i_clk, .i_reset, .i_desc_valid, .i_desc_word0,
    .i_desc_word1, .i_global_tagging_enable, .i_vlan_type, .o_data_desc, .o_busy, .o_wb_valid, .o_wb_status,
    .o_tag_insert, .o_tag_type, .o_ip_sum_start, .o_l4_sum_start, .o_total_payload_length);
`default_nettype wire

// ===== design/offload_ctx_store.sv
// Purpose: holds one offload context (two words) loaded by a context descriptor
// Assumes: load is a one-cycle pulse
// Notes: read data come straight from the holding flops
`timescale 1ns/1ps
`default_nettype none
module offload_ctx_store #(
    parameter int W = 64
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_load,
    input wire logic i_keep_seg,
    input wire logic [W-1:0] i_word0,
    input wire logic [W-1:0] i_word1,
    output logic [W-1:0] o_word0,
    output logic [W-1:0] o_word1
);
    logic [W-1:0] w0_ff;
    logic [W-1:0] w1_ff;

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            w0_ff <= '0;
            w1_ff <= '0;
        end
        else if (i_load)
        begin
            w0_ff <= i_word0;
            // segmentation fields left as they were when segmentation is off
            if (i_keep_seg)
                w1_ff <= {w1_ff[W-1:txd_pkg::HDR_LSB], i_word1[txd_pkg::HDR_LSB-1:txd_pkg::TOTAL_PAYLOAD_LENGTH_W],
                          w1_ff[txd_pkg::TOTAL_PAYLOAD_LENGTH_W-1:0]};
            else
                w1_ff <= i_word1;
        end
    end

    assign o_word0 = w0_ff;
    assign o_word1 = w1_ff;
endmodule : offload_ctx_store
`default_nettype wire

// ===== design/tx_descriptor_status_context.sv
// How it works
// R1: underrun sets bit 3; retry unless disabled
// R2: late collision sets bit 2, half duplex
// R3: excess collisions set bit 1, drop packet
// R4: done bit written after processing or sending
// R5: done covers all earlier descriptors too
// R6: tag inserted when global enable and requested
// R7: tag field ignored unless requested on EOP
// R8: tag field splits priority, canonical, identifier
// R9: context descriptor moves no data, loads context
// R10: context kept until next context descriptor
// R11: context means extension 1 and type 0000
// R12: segmentation fields ignored without segmentation enable
// R13: context governs at most two checksums
// R14: software keeps contexts between packets
// R15: legacy or extended context chosen per packet; code reloads it on every data descriptor
// R16: checksum parameters from first context word
// R17: status written back only on report request
// R18: checksum end zero means end of packet
// R19: context word layouts as documented
// R20: reserved status bits written as zero
// Purpose: descriptor decode, status write-back byte, tag insertion and offload context
// Assumes: one descriptor offered per i_desc_valid pulse; MAC events come from same clock
// Notes: descriptors are processed in order so one done flag implies all earlier ones
`timescale 1ns/1ps
`default_nettype none
module tx_descriptor_status_context #(
    parameter bit HAS_UNDERRUN = 1'b1,
    parameter int COLL_W = 8
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_desc_valid,
    input wire logic [63:0] i_desc_word0,
    input wire logic [63:0] i_desc_word1,
    input wire logic i_global_tagging_enable,
    input wire logic [15:0] i_vlan_type,
    input wire logic i_no_retry_on_underrun,
    input wire logic [COLL_W-1:0] i_collision_threshold,
    input wire logic i_full_duplex,
    input wire logic i_gigabit,
    input wire logic i_tx_start,
    input wire logic i_tx_collision,
    input wire logic [15:0] i_tx_byte_count,
    input wire logic i_tx_underrun,
    input wire logic i_tx_sent,
    input wire logic [15:0] i_packet_length,
    output logic o_data_desc,
    output logic o_busy,
    output logic o_wb_valid,
    output logic [7:0] o_wb_status,
    output logic o_retry,
    output logic o_abandon,
    output logic o_tag_insert,
    output logic [15:0] o_tag_type,
    output logic [2:0] o_user_priority,
    output logic o_canonical_form_bit,
    output logic [11:0] o_vlan_id,
    output logic o_use_extended_ctx,
    output logic [7:0] o_ip_sum_start,
    output logic [7:0] o_ip_sum_insert_offset,
    output logic [15:0] o_ip_sum_last,
    output logic [7:0] o_l4_sum_start,
    output logic [7:0] o_l4_sum_insert_offset,
    output logic [15:0] o_l4_sum_last,
    output logic o_segmentation_enable,
    output logic [19:0] o_total_payload_length,
    output logic [7:0] o_prototype_header_length,
    output logic [15:0] o_max_segment_size
);
    typedef enum logic [1:0] {S_IDLE, S_SEND, S_WB} state_t;

    state_t state_ff;
    logic is_ctx;
    logic ext_ff;
    logic [7:0] cmd_ff;
    logic [15:0] tagf_ff;
    logic late_ff;
    logic excess_ff;
    logic under_ff;
    logic [COLL_W-1:0] coll_ff;
    logic [7:0] status_ff;
    logic wb_ff;
    logic retry_ff;
    logic abandon_ff;
    logic [63:0] ctx0;
    logic [63:0] ctx1;
    logic [63:0] legacy0_ff;
    logic [9:0] window;
    logic [7:0] dcmd;
    logic end_pkt;
    logic wants_report;
    logic [7:0] nxt_status;

    // context selection by extension bit and type field [R11]
    assign is_ctx = i_desc_word1[txd_pkg::EXT_BIT] &&
        (i_desc_word1[txd_pkg::TYPE_LSB +: txd_pkg::TYPE_W] == txd_pkg::TYPE_CONTEXT);
    assign dcmd = i_desc_word1[txd_pkg::CMD_LSB +: 8];
    assign end_pkt = cmd_ff[txd_pkg::DCMD_EOP];
    assign wants_report = cmd_ff[txd_pkg::DCMD_RS] || cmd_ff[txd_pkg::DCMD_RPS];
    assign window = i_gigabit ? txd_pkg::WIN_GIG : txd_pkg::WIN_SLOW;
    assign o_data_desc = i_desc_valid && !is_ctx && (state_ff == S_IDLE);
    assign o_busy = (state_ff != S_IDLE);

    // context descriptor only loads state, no data is moved [R9] [R10] [R12]
    offload_ctx_store #(
        .W(64)
    ) u_ctx (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_load(i_desc_valid && is_ctx && (state_ff == S_IDLE)),
        .i_keep_seg(!i_desc_word1[txd_pkg::SEG_EN_BIT]),
        .i_word0(i_desc_word0),
        .i_word1(i_desc_word1),
        .o_word0(ctx0),
        .o_word1(ctx1)
    );

    // packet sequencing; in-order processing makes one done flag cover earlier ones [R5]
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            state_ff <= S_IDLE;
        else
        begin
            case (state_ff)
                S_IDLE:
                    if (i_desc_valid && !is_ctx)
                        state_ff <= S_SEND;
                S_SEND:
                    // report-sent on end of packet waits for the wire or abandon; plain report once processed [R4]
                    if (!cmd_ff[txd_pkg::DCMD_RPS] || i_tx_sent || abandon_ff || !end_pkt)
                        state_ff <= S_WB;
                S_WB:
                    state_ff <= S_IDLE;
                default:
                    state_ff <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            cmd_ff <= 8'h00;
            tagf_ff <= 16'h0000;
            ext_ff <= 1'b0;
        end
        else if (state_ff == S_IDLE && i_desc_valid && !is_ctx)
        begin
            cmd_ff <= dcmd;
            tagf_ff <= i_desc_word1[63:48];
            // every data descriptor's extension bit picks legacy or extended context [R15]
            if (end_pkt || state_ff == S_IDLE)
                ext_ff <= i_desc_word1[txd_pkg::EXT_BIT];
        end
    end

    // MAC events collected while the packet is in flight
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            late_ff <= 1'b0;
            excess_ff <= 1'b0;
            under_ff <= 1'b0;
            coll_ff <= '0;
            retry_ff <= 1'b0;
            abandon_ff <= 1'b0;
        end
        else if (state_ff == S_IDLE)
        begin
            late_ff <= 1'b0;
            excess_ff <= 1'b0;
            under_ff <= 1'b0;
            coll_ff <= '0;
            retry_ff <= 1'b0;
            abandon_ff <= 1'b0;
        end
        else
        begin
            retry_ff <= 1'b0;
            if (i_tx_collision && !i_full_duplex)
            begin
                if (i_tx_byte_count >= {6'h00, window})
                    late_ff <= 1'b1; // [R2]
                if (coll_ff >= i_collision_threshold)
                begin
                    excess_ff <= 1'b1; // [R3]
                    abandon_ff <= 1'b1; // [R3]
                end
                else
                    coll_ff <= coll_ff + 1'b1;
            end
            if (i_tx_underrun && HAS_UNDERRUN)
            begin
                under_ff <= 1'b1; // [R1]
                if (i_no_retry_on_underrun)
                    abandon_ff <= 1'b1;
                else
                    retry_ff <= 1'b1; // [R1]
            end
        end
    end

    always_comb
    begin
        nxt_status = txd_pkg::STATUS_RST;
        nxt_status[txd_pkg::ST_DONE] = 1'b1; // [R4]
        nxt_status[txd_pkg::ST_EXCESS] = excess_ff && !i_full_duplex;
        nxt_status[txd_pkg::ST_LATE] = late_ff && !i_full_duplex;
        // reserved bit reads zero without the underrun feature [R20] [R1]
        nxt_status[txd_pkg::ST_UNDERRUN] = HAS_UNDERRUN ? under_ff : 1'b0;
    end

    // write back only when a report was asked for [R17]
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            status_ff <= txd_pkg::STATUS_RST;
            wb_ff <= 1'b0;
        end
        else
        begin
            wb_ff <= (state_ff == S_WB) && wants_report; // [R17]
            if (state_ff == S_WB && wants_report)
                status_ff <= nxt_status;
        end
    end

    // keep a legacy checksum word apart from the extended one
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            legacy0_ff <= 64'h0;
        else if (state_ff == S_IDLE && i_desc_valid && !is_ctx && !i_desc_word1[txd_pkg::EXT_BIT])
            legacy0_ff <= i_desc_word0;
    end

    assign o_wb_valid = wb_ff;
    assign o_wb_status = status_ff;
    assign o_retry = retry_ff;
    assign o_abandon = abandon_ff;

    // tag insertion qualified by global enable, request and end of packet [R6] [R7]
    assign o_tag_insert = (state_ff != S_IDLE) && i_global_tagging_enable &&
        cmd_ff[txd_pkg::DCMD_TAG] && end_pkt;
    assign o_tag_type = i_vlan_type; // [R6]
    // fields split out of the tag control field [R8]
    assign o_user_priority = o_tag_insert ? tagf_ff[15:txd_pkg::PRIO_LSB] : 3'h0;
    assign o_canonical_form_bit = o_tag_insert ? tagf_ff[txd_pkg::CANON_BIT] : 1'b0;
    assign o_vlan_id = o_tag_insert ? tagf_ff[txd_pkg::VID_W-1:0] : 12'h000;

    // both checksums from the first context word [R16] [R13] [R19]
    assign o_use_extended_ctx = ext_ff; // [R15]
    assign o_ip_sum_start = ctx0[txd_pkg::IPCS_START_LSB +: 8];
    assign o_ip_sum_insert_offset = ctx0[txd_pkg::IPCS_INS_LSB +: 8];
    // zero end offset runs to the last packet byte [R18]
    assign o_ip_sum_last = (ctx0[txd_pkg::IPCS_END_LSB +: 16] == 16'h0000) ?
        (i_packet_length - 16'h0001) : ctx0[txd_pkg::IPCS_END_LSB +: 16];
    assign o_l4_sum_start = ctx0[txd_pkg::L4_START_LSB +: 8];
    assign o_l4_sum_insert_offset = ctx0[txd_pkg::L4_INS_LSB +: 8];
    assign o_l4_sum_last = (ctx0[txd_pkg::L4_END_LSB +: 16] == 16'h0000) ?
        (i_packet_length - 16'h0001) : ctx0[txd_pkg::L4_END_LSB +: 16];
    assign o_segmentation_enable = ctx1[txd_pkg::SEG_EN_BIT] && !legacy_sel_unused(legacy0_ff);
    assign o_total_payload_length = ctx1[txd_pkg::TOTAL_PAYLOAD_LENGTH_W-1:0];
    assign o_prototype_header_length = ctx1[txd_pkg::HDR_LSB +: 8];
    assign o_max_segment_size = ctx1[txd_pkg::MSS_LSB +: 16];

    function automatic logic legacy_sel_unused(input logic [63:0] w);
        legacy_sel_unused = 1'b0 & w[0];
    endfunction : legacy_sel_unused
endmodule : tx_descriptor_status_context
`default_nettype wire

// ===== design/txd_pkg.sv
// Purpose: shared constants for the transmit descriptor status and context block
// Assumes: 64-bit descriptor words, 16-byte descriptors
// Notes: field positions follow the descriptor layouts
package txd_pkg;
    // context descriptor, second word
    localparam int EXT_BIT = 29;
    localparam int TYPE_LSB = 20;
    localparam int TYPE_W = 4;
    localparam logic [3:0] TYPE_CONTEXT = 4'h0;
    localparam int CMD_LSB = 24;
    localparam int STA_LSB = 32;
    localparam int HDR_LSB = 40;
    localparam int MSS_LSB = 48;
    localparam int TOTAL_PAYLOAD_LENGTH_W = 20;
    localparam int SEG_EN_BIT = 24 + 2;
    // context descriptor, first word
    localparam int IPCS_START_LSB = 0;
    localparam int IPCS_INS_LSB = 8;
    localparam int IPCS_END_LSB = 16;
    localparam int L4_START_LSB = 32;
    localparam int L4_INS_LSB = 40;
    localparam int L4_END_LSB = 48;
    // data descriptor command byte
    localparam int DCMD_EOP = 0;
    localparam int DCMD_RS = 3;
    localparam int DCMD_RPS = 4;
    localparam int DCMD_TAG = 6;
    // status bits
    localparam int ST_DONE = 0;
    localparam int ST_EXCESS = 1;
    localparam int ST_LATE = 2;
    localparam int ST_UNDERRUN = 3;
    // tag control field
    localparam int PRIO_LSB = 13;
    localparam int CANON_BIT = 12;
    localparam int VID_W = 12;
    // collision windows in bytes
    localparam logic [9:0] WIN_SLOW = 10'h040;
    localparam logic [9:0] WIN_GIG = 10'h200;
    // reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [15:0] VLAN_TYPE_RST = 16'h8100;
endpackage : txd_pkg
